// ### design/bst_params.svh
// Purpose: shared constants of the boundary scan port and its controller
// Assumes: 100 MHz system clock on both ends
// Notes: identification value below is arbitrary
`ifndef BST_PARAMS_SVH
`define BST_PARAMS_SVH

// sizes
`define BST_IR_W 4
`define BST_PINS 6
`define BST_NPAT 8
`define BST_ID_W 32
`define BST_MAP_W 48
`define BST_VEC_W 24
`define BST_DR_DATA 12

// instruction codes
`define BST_OP_EXTEST 4'h0
`define BST_OP_IDCODE 4'h1
`define BST_OP_SAMPLE 4'h2
`define BST_OP_BYPASS 4'hf

// fixed words; identification value is arbitrary
`define BST_IR_STATUS 4'h1
`define BST_IDCODE 32'h1234_5001

// synchroniser bit positions on the device
`define BST_SY_TCK 0
`define BST_SY_TMS 1
`define BST_SY_TDI 2
`define BST_SY_TRST 3

// timing
`define BST_CLK_MHZ 100
`define BST_TCK_HALF_NS 80
`define BST_TCK_HALF_CYC ((`BST_TCK_HALF_NS*`BST_CLK_MHZ+999)/1000)
`define BST_RESET_TMS 5

// scan sequence lengths in test clocks, and index of the last scan
`define BST_RST_LEN 5'h06
`define BST_IR_LEN 5'h0e
`define BST_DR_LEN 5'h11
`define BST_LAST_OP 3'h4

`endif

// ### design/bst_pkg.sv
// Purpose: types shared by the device port and the test controller
// Assumes: constants come from bst_params.svh
// Notes: states are one-hot
`include "bst_params.svh"
`default_nettype none
package bst_pkg;

  typedef enum logic [15:0] {
    st_reset = 16'h0001, st_idle = 16'h0002, st_sel_dr = 16'h0004,
    st_cap_dr = 16'h0008, st_shift_dr = 16'h0010, st_exit1_dr = 16'h0020,
    st_pause_dr = 16'h0040, st_exit2_dr = 16'h0080, st_upd_dr = 16'h0100,
    st_sel_ir = 16'h0200, st_cap_ir = 16'h0400, st_shift_ir = 16'h0800,
    st_exit1_ir = 16'h1000, st_pause_ir = 16'h2000, st_exit2_ir = 16'h4000,
    st_upd_ir = 16'h8000
  } bst_tap_e;

  typedef enum logic [2:0] {
    hs_idle = 3'h1, hs_run = 3'h2, hs_eval = 3'h4
  } bst_host_e;

  typedef struct packed {
    logic [3:0] sy1;
    logic [3:0] sy2;
    logic tck_q;
    logic [`BST_PINS-1:0] pin_s1;
    logic [`BST_PINS-1:0] pin_s2;
    bst_tap_e state;
    logic [`BST_IR_W-1:0] ir_sr;
    logic [`BST_IR_W-1:0] ir;
    logic [`BST_PINS-1:0] bsr;
    logic [`BST_PINS-1:0] bsr_upd;
    logic [`BST_PINS-1:0] pin_o;
    logic byp;
    logic [`BST_ID_W-1:0] id_sr;
    logic tdo;
    logic tdo_oe_n;
    logic extest;
  } bst_dev_s;

  typedef struct packed {
    logic [4:0] len;
    logic [`BST_VEC_W-1:0] dv;
    logic [`BST_VEC_W-1:0] tms;
    logic [`BST_VEC_W-1:0] tdi;
  } bst_seq_s;

  typedef struct packed {
    logic sy1;
    logic sy2;
    logic [3:0] div;
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
    bst_host_e state;
    logic [2:0] pat;
    logic [2:0] op;
    logic [4:0] step;
    bst_seq_s seq;
    logic [`BST_DR_DATA-1:0] cap;
    logic [`BST_MAP_W-1:0] capt;
    logic [`BST_MAP_W-1:0] fail;
    logic [`BST_PINS-1:0] open_m;
    logic [`BST_PINS-1:0] short_m;
    logic done;
    logic busy;
  } bst_host_s;

endpackage
`default_nettype wire

// ### design/bst_link_if.sv
// Purpose: five-pin test access link between controller and one device
// Assumes: tdo line is pulled high when the device releases it
// Notes: for a chain, one link per device, next tdi from tdo_line
`default_nettype none
interface bst_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic trst_n;
  logic tdo;
  logic tdo_oe_n;
  wire logic tdo_line;

  // released output reads as pulled high
  assign tdo_line = tdo_oe_n ? 1'b1 : tdo;

  modport dev (input tck, input tms, input tdi, input trst_n,
               output tdo, output tdo_oe_n);
  modport host (output tck, output tms, output tdi, output trst_n,
                input tdo_line);
endinterface
`default_nettype wire

// ### design/bst_tap_dev.sv
// Purpose: device test access port with boundary, bypass and id registers
// Assumes: link pins are asynchronous to mclk and sampled twice
// Notes: tck must stay below a quarter of the mclk rate
//
// How it works
// R01 - five pins: tdi, tdo, tck, tms, trst_n
// R02 - tdi, tms taken on tck rise; trst_n acts on every mclk
// R03 - tdo changes only on tck fall
// R04 - tdi feeds ir or dr by state
// R05 - tms steers states, trst_n resets controller
// R06 - board chains tdo into next tdi
// R07 - data passes through unaltered
// R08 - controller fans tck, tms, trst_n out
// R09 - preload, extest driver, sample receiver
// R10 - eight patterns: zeros, walking one, ones
// R11 - identical captures in all patterns: short
// R12 - always-zero capture: open or grounded
// R13 - cluster captures checked against predicted values
// R14 - reset on power-on, trst_n, five tms highs
// R15 - reset state loads identification instruction
// R16 - extest drives pins; sample keeps core running
// R17 - controller records per-pattern per-net mismatches
`include "bst_params.svh"
`default_nettype none
module bst_tap_dev (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // test access link
  bst_link_if.dev link,
  // core side
  input wire logic [`BST_PINS-1:0] core_o,
  input wire logic [`BST_PINS-1:0] pin_i,
  output logic [`BST_PINS-1:0] pin_o,
  output logic extest,
  output logic [`BST_IR_W-1:0] inst
);

  bst_pkg::bst_dev_s r;
  bst_pkg::bst_dev_s n;
  logic rise;
  logic fall;
  logic tms;
  logic tdi;
  logic sel_bsr;
  logic sel_id;
  logic lsb;

  function automatic bst_pkg::bst_tap_e tap_next(
    input bst_pkg::bst_tap_e s, input logic m);
    bst_pkg::bst_tap_e t;
    t = bst_pkg::st_reset;
    case (s)
      bst_pkg::st_reset: begin
        t = m ? bst_pkg::st_reset : bst_pkg::st_idle;
      end
      bst_pkg::st_idle: begin
        t = m ? bst_pkg::st_sel_dr : bst_pkg::st_idle;
      end
      bst_pkg::st_sel_dr: begin
        t = m ? bst_pkg::st_sel_ir : bst_pkg::st_cap_dr;
      end
      bst_pkg::st_cap_dr: begin
        t = m ? bst_pkg::st_exit1_dr : bst_pkg::st_shift_dr;
      end
      bst_pkg::st_shift_dr: begin
        t = m ? bst_pkg::st_exit1_dr : bst_pkg::st_shift_dr;
      end
      bst_pkg::st_exit1_dr: begin
        t = m ? bst_pkg::st_upd_dr : bst_pkg::st_pause_dr;
      end
      bst_pkg::st_pause_dr: begin
        t = m ? bst_pkg::st_exit2_dr : bst_pkg::st_pause_dr;
      end
      bst_pkg::st_exit2_dr: begin
        t = m ? bst_pkg::st_upd_dr : bst_pkg::st_shift_dr;
      end
      bst_pkg::st_upd_dr: begin
        t = m ? bst_pkg::st_sel_dr : bst_pkg::st_idle;
      end
      bst_pkg::st_sel_ir: begin
        t = m ? bst_pkg::st_reset : bst_pkg::st_cap_ir;
      end
      bst_pkg::st_cap_ir: begin
        t = m ? bst_pkg::st_exit1_ir : bst_pkg::st_shift_ir;
      end
      bst_pkg::st_shift_ir: begin
        t = m ? bst_pkg::st_exit1_ir : bst_pkg::st_shift_ir;
      end
      bst_pkg::st_exit1_ir: begin
        t = m ? bst_pkg::st_upd_ir : bst_pkg::st_pause_ir;
      end
      bst_pkg::st_pause_ir: begin
        t = m ? bst_pkg::st_exit2_ir : bst_pkg::st_pause_ir;
      end
      bst_pkg::st_exit2_ir: begin
        t = m ? bst_pkg::st_upd_ir : bst_pkg::st_shift_ir;
      end
      bst_pkg::st_upd_ir: begin
        t = m ? bst_pkg::st_sel_dr : bst_pkg::st_idle;
      end
      default: begin
        t = bst_pkg::st_reset;
      end
    endcase
    return t;
  endfunction

  // edges of the sampled test clock
  assign rise = r.sy2[`BST_SY_TCK] & ~r.tck_q; // R02
  assign fall = ~r.sy2[`BST_SY_TCK] & r.tck_q; // R03
  assign tms = r.sy2[`BST_SY_TMS];
  assign tdi = r.sy2[`BST_SY_TDI];

  // register chosen between tdi and tdo
  assign sel_bsr = (r.ir == `BST_OP_EXTEST) || (r.ir == `BST_OP_SAMPLE);
  assign sel_id = (r.ir == `BST_OP_IDCODE);

  always_comb begin
    if (r.state == bst_pkg::st_shift_ir) begin
      lsb = r.ir_sr[0];
    end else if (sel_bsr) begin
      lsb = r.bsr[0];
    end else if (sel_id) begin
      lsb = r.id_sr[0];
    end else begin
      lsb = r.byp;
    end
  end

  always_comb begin
    n = r;
    // two-stage sampling of the link and the pins
    n.sy1 = {link.trst_n, link.tdi, link.tms, link.tck}; // R01
    n.sy2 = r.sy1;
    n.tck_q = r.sy2[`BST_SY_TCK];
    n.pin_s1 = pin_i;
    n.pin_s2 = r.pin_s1;
    if (rise) begin
      case (r.state)
        bst_pkg::st_cap_dr: begin
          if (sel_bsr) begin
            n.bsr = r.pin_s2; // R16
          end
          n.id_sr = `BST_IDCODE;
          n.byp = 1'b0;
        end
        bst_pkg::st_shift_dr: begin
          if (sel_bsr) begin
            n.bsr = {tdi, r.bsr[`BST_PINS-1:1]}; // R04
          end else if (sel_id) begin
            n.id_sr = {tdi, r.id_sr[`BST_ID_W-1:1]}; // R07
          end else begin
            n.byp = tdi; // R07
          end
        end
        bst_pkg::st_upd_dr: begin
          if (sel_bsr) begin
            n.bsr_upd = r.bsr;
          end
        end
        bst_pkg::st_cap_ir: begin
          n.ir_sr = `BST_IR_STATUS;
        end
        bst_pkg::st_shift_ir: begin
          n.ir_sr = {tdi, r.ir_sr[`BST_IR_W-1:1]}; // R04
        end
        bst_pkg::st_upd_ir: begin
          n.ir = r.ir_sr;
        end
        default: begin
        end
      endcase
      n.state = tap_next(r.state, tms); // R05
    end
    // drive tdo only while shifting, and only on the falling edge
    if (fall) begin
      if ((r.state == bst_pkg::st_shift_dr) ||
          (r.state == bst_pkg::st_shift_ir)) begin
        n.tdo = lsb; // R03
        n.tdo_oe_n = 1'b0; // R03
      end else begin
        n.tdo_oe_n = 1'b1; // R03
      end
    end
    // reset state holds the identification instruction
    if (r.state == bst_pkg::st_reset) begin
      n.ir = `BST_OP_IDCODE; // R15
    end
    if (!r.sy2[`BST_SY_TRST]) begin
      n.state = bst_pkg::st_reset; // R05 R14
      n.tdo_oe_n = 1'b1;
    end
    // extest cuts the core off the pins
    n.extest = (r.ir == `BST_OP_EXTEST);
    n.pin_o = (r.ir == `BST_OP_EXTEST) ? r.bsr_upd : core_o; // R16
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
      r.state <= bst_pkg::st_reset; // R14
      r.ir <= `BST_OP_IDCODE; // R15
      r.tdo_oe_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // outputs
  assign link.tdo = r.tdo;
  assign link.tdo_oe_n = r.tdo_oe_n;
  assign pin_o = r.pin_o;
  assign extest = r.extest;
  assign inst = r.ir;

endmodule
`default_nettype wire

// ### design/bst_tap_host.sv
// Purpose: test controller running the interconnect and cluster tests
// Assumes: chain of two devices, driver nearest tdi, receiver last
// Notes: tck made here by dividing mclk
`include "bst_params.svh"
`default_nettype none
module bst_tap_host (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // test access link
  bst_link_if.host link,
  // user side
  input wire logic start,
  input wire logic cluster,
  input wire logic [`BST_MAP_W-1:0] expect_tab,
  output logic busy,
  output logic done,
  output logic [`BST_MAP_W-1:0] fail_map,
  output logic [`BST_PINS-1:0] open_mask,
  output logic [`BST_PINS-1:0] short_mask
);

  localparam logic [3:0] HALF_M1 = 4'(`BST_TCK_HALF_CYC - 1);

  bst_pkg::bst_host_s r;
  bst_pkg::bst_host_s n;

  // zeros, a one walking across the pins, then ones
  function automatic logic [`BST_PINS-1:0] pattern(input logic [2:0] p);
    logic [`BST_PINS-1:0] v;
    v = '0;
    if (p == 3'(`BST_NPAT - 1)) begin
      v = '1;
    end else if (p != 3'h0) begin
      v = 6'h01 << (p - 3'h1);
    end
    return v; // R10
  endfunction

  // tms, tdi and capture masks of one scan, lsb first
  function automatic bst_pkg::bst_seq_s gen(input logic [2:0] o,
                                            input logic [2:0] p);
    bst_pkg::bst_seq_s s;
    logic [`BST_PINS-1:0] a;
    s = '0;
    a = pattern(p);
    case (o)
      3'h0: begin
        s.len = `BST_RST_LEN;
        s.tms = 24'h00001f;
      end
      3'h1, 3'h3: begin
        s.len = `BST_IR_LEN;
        s.tms = 24'h001803;
        s.dv = 24'h000ff0;
        s.tdi[7:4] = `BST_OP_SAMPLE;
        s.tdi[11:8] = (o == 3'h1) ? `BST_OP_SAMPLE : `BST_OP_EXTEST; // R09
      end
      default: begin
        s.len = `BST_DR_LEN;
        s.tms = 24'h00c001;
        s.dv = 24'h007ff8;
        s.tdi[14:3] = {a, a}; // R09
      end
    endcase
    return s;
  endfunction

  always_comb begin
    logic ld;
    logic [2:0] lop;
    logic [2:0] lpat;
    logic [`BST_PINS-1:0] ex;
    logic [`BST_NPAT-1:0] col [`BST_PINS];
    ld = 1'b0;
    lop = 3'h0;
    lpat = 3'h0;
    ex = '0;
    for (int i = 0; i < `BST_PINS; i++) begin
      col[i] = '0;
    end
    n = r;
    n.done = 1'b0;
    n.sy1 = link.tdo_line;
    n.sy2 = r.sy1;
    case (r.state)
      bst_pkg::hs_idle: begin
        n.tck = 1'b0;
        n.trst_n = 1'b0;
        if (start) begin
          ld = 1'b1;
          n.trst_n = 1'b1;
          n.busy = 1'b1;
          n.div = 4'h0;
          n.capt = '0;
          n.fail = '0;
          n.state = bst_pkg::hs_run;
        end
      end
      bst_pkg::hs_run: begin
        if (r.div == HALF_M1) begin
          n.div = 4'h0;
          n.tck = ~r.tck; // R08
          if (!r.tck) begin
            if (r.seq.dv[r.step]) begin
              n.cap = {r.sy2, r.cap[`BST_DR_DATA-1:1]}; // R06
            end
          end else if (r.step == r.seq.len - 5'h1) begin
            if (r.op == `BST_LAST_OP) begin
              ex = cluster ? expect_tab[int'(r.pat)*`BST_PINS +: `BST_PINS]
                           : pattern(r.pat); // R13
              n.capt[int'(r.pat)*`BST_PINS +: `BST_PINS] =
                r.cap[`BST_PINS-1:0];
              n.fail[int'(r.pat)*`BST_PINS +: `BST_PINS] =
                r.cap[`BST_PINS-1:0] ^ ex; // R17
              if (r.pat == 3'(`BST_NPAT - 1)) begin
                n.state = bst_pkg::hs_eval;
              end else begin
                ld = 1'b1;
                lpat = r.pat + 3'h1;
              end
            end else begin
              ld = 1'b1;
              lop = r.op + 3'h1;
              lpat = r.pat;
            end
          end else begin
            n.step = r.step + 5'h1;
            n.tms = r.seq.tms[r.step + 5'h1];
            n.tdi = r.seq.tdi[r.step + 5'h1];
          end
        end else begin
          n.div = r.div + 4'h1;
        end
      end
      bst_pkg::hs_eval: begin
        for (int i = 0; i < `BST_PINS; i++) begin
          for (int p = 0; p < `BST_NPAT; p++) begin
            col[i][p] = r.capt[p*`BST_PINS + i];
          end
        end
        for (int i = 0; i < `BST_PINS; i++) begin
          n.open_m[i] = ~|col[i]; // R12
          n.short_m[i] = 1'b0;
          for (int j = 0; j < `BST_PINS; j++) begin
            if ((j != i) && (col[i] == col[j])) begin
              n.short_m[i] = 1'b1; // R11
            end
          end
        end
        n.done = 1'b1;
        n.busy = 1'b0;
        n.state = bst_pkg::hs_idle;
      end
      default: begin
        n.state = bst_pkg::hs_idle;
      end
    endcase
    if (ld) begin
      n.op = lop;
      n.pat = lpat;
      n.step = 5'h0;
      n.seq = gen(lop, lpat);
      n.tms = n.seq.tms[0];
      n.tdi = n.seq.tdi[0];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
      r.state <= bst_pkg::hs_idle;
    end else begin
      r <= n;
    end
  end

  // outputs
  assign link.tck = r.tck;
  assign link.tms = r.tms;
  assign link.tdi = r.tdi;
  assign link.trst_n = r.trst_n;
  assign busy = r.busy;
  assign done = r.done;
  assign fail_map = r.fail;
  assign open_mask = r.open_m;
  assign short_mask = r.short_m;

endmodule
`default_nettype wire

// ### tb/bst_link_asserts.sv
// Purpose: link checks between controller and receiving device
// Assumes: controller makes tck as 8 mclk high, 8 mclk low
// Notes: one clock domain, mclk
`default_nettype none
module bst_link_asserts (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // link as seen at the receiving device
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tck_last;
  logic [2:0] ones_cnt;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // count tck rises with tms high
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tck_last <= 1'b0;
      ones_cnt <= 3'h0;
    end else begin
      tck_last <= tck;
      if (tck && !tck_last) begin
        if (!tms) ones_cnt <= 3'h0;
        else if (ones_cnt != 3'h7) ones_cnt <= ones_cnt + 3'h1;
      end
    end
  end

  chk_tdo_fall_only: assert property (
    $changed(tdo) && trst_n && $past(trst_n, 4)
      |-> !tck && !$past(tck) && $past(tck, 6))
    else $error("tdo moved away from a tck fall");
  chk_oe_fall_only: assert property (
    $fell(tdo_oe_n) |-> !tck && !$past(tck) && $past(tck, 6))
    else $error("tdo driven away from a tck fall");
  chk_trst_release: assert property (
    $fell(trst_n) ##1 !trst_n [*6] |-> tdo_oe_n)
    else $error("tdo still driven under test reset");
  chk_five_ones: assert property (
    ones_cnt >= 3'h5 |-> tdo_oe_n)
    else $error("tdo driven after five tms highs");
  chk_tck_half: assert property (
    $rose(tck) |-> tck [*8] ##1 !tck)
    else $error("tck high phase not 8 cycles");
  chk_in_stable: assert property (
    $rose(tck) |-> $stable({tms, tdi, trst_n}) [*8])
    else $error("inputs moved while tck high");
  chk_trst_tck_low: assert property (
    $changed(trst_n) |-> !tck && !$past(tck))
    else $error("test reset moved while tck high");
  chk_por_release: assert property (
    $rose(rstn) |-> tdo_oe_n && !tdo)
    else $error("tdo not released after reset");
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Purpose: chain test of controller, driving and receiving device
// Assumes: driver pins reach receiver through a fault model
// Notes: expected maps queued at start, compared on done
`include "bst_params.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [47:0] fail;
    logic [5:0] opn;
    logic [5:0] shr;
  } bst_exp_s;

  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic start = 1'b0;
  logic cluster = 1'b0;
  logic [47:0] expect_tab = 48'h0;
  logic [5:0] core_d = 6'h0;
  logic [5:0] core_r = 6'h0;
  logic busy, done, drv_ext, rx_ext;
  logic [47:0] fail_map;
  logic [5:0] open_mask, short_mask, drv_pin_o, rx_pin_o, rx_pin_i;
  logic [3:0] drv_inst, rx_inst;
  int fault = 0;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  bit saw_ext = 1'b0;
  bst_exp_s expq[$];
  bst_exp_s got;

  function automatic logic [5:0] pat_of(int p);
    if (p == 0) return 6'h00;
    if (p == 7) return 6'h3f;
    return 6'h01 << (p - 1);
  endfunction

  // board between the devices: 1 open pin2, 2 pins 3/4 shorted, 3 inverter
  function automatic logic [5:0] wire_of(int m, logic [5:0] v);
    case (m)
      1: return v & 6'h3b;
      2: return (v[3] | v[4]) ? (v | 6'h18) : v;
      3: return ~v;
      default: return v;
    endcase
  endfunction

  function automatic logic [47:0] inv_tab();
    logic [47:0] t;
    for (int p = 0; p < 8; p++) t[p*6 +: 6] = ~pat_of(p);
    return t;
  endfunction

  always #5 mclk = ~mclk;

  bst_link_if link_h ();
  bst_link_if link_d ();
  bst_link_if link_r ();
  assign link_d.tck = link_h.tck;
  assign link_d.tms = link_h.tms;
  assign link_d.trst_n = link_h.trst_n;
  assign link_d.tdi = link_h.tdi;
  assign link_r.tck = link_h.tck;
  assign link_r.tms = link_h.tms;
  assign link_r.trst_n = link_h.trst_n;
  assign link_r.tdi = link_d.tdo_line;
  assign link_h.tdo = link_r.tdo_line;
  assign link_h.tdo_oe_n = 1'b0;
  assign rx_pin_i = wire_of(fault, drv_pin_o);

  bst_tap_host i_bst_tap_host (
    .mclk(mclk), .rstn(rstn), .link(link_h.host), .start(start),
    .cluster(cluster), .expect_tab(expect_tab), .busy(busy), .done(done),
    .fail_map(fail_map), .open_mask(open_mask), .short_mask(short_mask));
  bst_tap_dev i_bst_tap_dev (
    .mclk(mclk), .rstn(rstn), .link(link_d.dev), .core_o(core_d),
    .pin_i(drv_pin_o), .pin_o(drv_pin_o), .extest(drv_ext),
    .inst(drv_inst));
  bst_tap_dev i_bst_tap_dev_rx (
    .mclk(mclk), .rstn(rstn), .link(link_r.dev), .core_o(core_r),
    .pin_i(rx_pin_i), .pin_o(rx_pin_o), .extest(rx_ext), .inst(rx_inst));
  bst_link_asserts i_bst_link_asserts (
    .mclk(mclk), .rstn(rstn), .tck(link_r.tck), .tms(link_r.tms),
    .tdi(link_r.tdi), .trst_n(link_r.trst_n), .tdo(link_r.tdo),
    .tdo_oe_n(link_r.tdo_oe_n));

  task automatic chk(string what, logic [47:0] seen, logic [47:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    if (err_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // one full test; expected maps worked out from the board model
  task automatic run(int m, logic clu, logic [47:0] etab);
    bst_exp_s e;
    logic [5:0] c;
    logic [5:0] any;
    logic [7:0] col [6];
    int n;
    e = '0;
    any = 6'h0;
    for (int p = 0; p < 8; p++) begin
      c = wire_of(m, pat_of(p));
      e.fail[p*6 +: 6] = c ^ (clu ? etab[p*6 +: 6] : pat_of(p));
      any = any | c;
      for (int i = 0; i < 6; i++) col[i][p] = c[i];
    end
    e.opn = ~any;
    for (int i = 0; i < 6; i++)
      for (int j = 0; j < 6; j++)
        if (i != j && col[i] == col[j]) e.shr[i] = 1'b1;
    fault = m;
    cluster = clu;
    expect_tab = etab;
    core_d = 6'($urandom);
    core_r = 6'($urandom);
    saw_ext = 1'b0;
    expq.push_back(e);
    @(posedge mclk) #1 start = 1'b1;
    @(posedge mclk) #1 start = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 12000) begin
      @(posedge mclk) #1;
      n++;
    end
    chk("busy at end", 48'(busy), 48'h0);
    repeat (10) @(posedge mclk);
    #1;
    chk("driver extest seen", 48'(saw_ext), 48'h1);
    chk("driver inst", 48'(drv_inst), 48'(`BST_OP_IDCODE));
    chk("receiver inst", 48'(rx_inst), 48'(`BST_OP_IDCODE));
    chk("driver pins", 48'(drv_pin_o), 48'(core_d));
  endtask

  // reset in the middle of a test
  task automatic abort_run();
    @(posedge mclk) #1 start = 1'b1;
    @(posedge mclk) #1 start = 1'b0;
    repeat (3000) @(posedge mclk);
    #1 rstn = 1'b0;
    @(posedge mclk) #1;
    chk("busy in reset", 48'(busy), 48'h0);
    chk("tdo in reset", 48'(link_r.tdo_oe_n), 48'h1);
    chk("inst in reset", 48'(drv_inst), 48'(`BST_OP_IDCODE));
    rstn = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
  endtask

  always @(negedge mclk) begin
    cyc++;
    if (drv_ext === 1'b1) saw_ext = 1'b1;
    if (busy === 1'b1) begin
      chk("receiver pins", 48'(rx_pin_o), 48'(core_r));
      chk("receiver extest", 48'(rx_ext), 48'h0);
    end
    if (done === 1'b1) begin
      if (expq.size() == 0) begin
        chk("extra done", 48'h1, 48'h0);
      end else begin
        got = expq.pop_front();
        chk("fail_map", fail_map, got.fail);
        chk("open_mask", 48'(open_mask), 48'(got.opn));
        chk("short_mask", 48'(short_mask), 48'(got.shr));
      end
    end
    if (cyc == 60000) begin
      err_count++;
      stop_test();
    end
  end

  initial begin
    void'($urandom(32'h8a94a4f9));
    repeat (12) @(posedge mclk);
    #1 rstn = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    run(0, 1'b0, 48'h0);
    run(1, 1'b0, 48'h0);
    run(2, 1'b0, 48'h0);
    abort_run();
    run(3, 1'b1, inv_tab() ^ (48'h1 << $urandom_range(47, 0)));
    chk("queue empty", 48'(expq.size()), 48'h0);
    stop_test();
  end
endmodule
`default_nettype wire
